// *** core/monitor_aux_map.vh ***
// Purpose: Offsets, field positions, reset values and timing constants
//          of the auxiliary monitor control register bank.
// Assumes: 8-bit register port, 100 MHz reference clock.
// Notes:   Definitions only.
`ifndef MONITOR_AUX_MAP_VH
`define MONITOR_AUX_MAP_VH

// Register offsets
`define MA_ADDR_INT_HIGH_LIMIT   8'h13
`define MA_ADDR_EXT_HIGH_LIMIT   8'h14
`define MA_ADDR_FIRST_CONFIG     8'h40
`define MA_ADDR_INTRUSION_CLEAR  8'h46
`define MA_ADDR_VID_FAN_DIV      8'h47
`define MA_ADDR_FIFTH_VID        8'h49
`define MA_ADDR_SECOND_CONFIG    8'h4A
`define MA_ADDR_STATUS_MIRROR    8'h4C

// Field positions
`define MA_INTRUSION_REQ_BIT     7
`define MA_RESTORE_DEFAULTS_BIT  7
`define MA_FAN1_DIV_LSB          4
`define MA_FAN2_DIV_LSB          6
`define MA_CFG2_THERMAL_ALARM_OUT_INT_MASK   0
`define MA_CFG2_INT_LIMIT_LOCK   1
`define MA_CFG2_EXT_LIMIT_LOCK   2
`define MA_CFG2_ALARM_MODE       3
`define MA_CFG2_ID3_IRQ_SEL      6
`define MA_CFG2_ID4_IRQ_SEL      7
`define MA_CFG2_WRITABLE_MASK    8'hCF

// Reset values
`define MA_INTRUSION_RESET       8'h00
`define MA_FAN_DIV_RESET         4'h5
`define MA_FIFTH_VID_RSV_RESET   7'h40
`define MA_SECOND_CONFIG_RESET   8'h00
`define MA_HIGH_LIMIT_RESET      8'h00
`define MA_READ_UNMAPPED         8'h00

// Fan divider ratios per code
`define MA_DIV_CODE_1            2'h0
`define MA_DIV_CODE_2            2'h1
`define MA_DIV_CODE_4            2'h2
`define MA_DIV_RATIO_1           4'h1
`define MA_DIV_RATIO_2           4'h2
`define MA_DIV_RATIO_4           4'h4
`define MA_DIV_RATIO_8           4'h8

// Timing
`define MA_INTRUSION_PULSE_MS    20
`define MA_REF_CLK_KHZ           100000

`endif

// *** core/monitor_aux_control_registers.v ***
// Purpose: Auxiliary control and status registers of a hardware monitor:
//          intrusion clear pulse, voltage-ID readback, fan divisors,
//          second configuration and status mirror.
// Assumes: A serial-bus engine presents decoded register accesses, one
//          access per cycle, synchronous to ref_clk_i.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_aux_map.vh"

module monitor_aux_control_registers #(
	parameter integer INTRUSION_PULSE_CYCLES =
		`MA_INTRUSION_PULSE_MS * `MA_REF_CLK_KHZ
) (
	// Clock and reset
	input  wire       ref_clk_i,
	input  wire       reset_i,
	// Register port from the serial-bus engine
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output reg  [7:0] reg_rdata_o,
	// Chassis intrusion open-drain pin
	input  wire       chassis_intrusion_pin_i,
	output wire       chassis_intrusion_pin_o,
	output wire       chassis_intrusion_pin_oe_n_o,
	// Voltage-ID pins
	input  wire [3:0] voltage_id_low_nibble_i,
	input  wire       fifth_voltage_id_input_i,
	// Fan tachometer divider ratios
	output wire [3:0] first_fan_divider_o,
	output wire [3:0] second_fan_divider_o,
	// Temperature high limits
	output wire [7:0] int_temp_high_limit_o,
	output wire [7:0] ext_temp_high_limit_o,
	// Thermal and interrupt routing
	input  wire       thermal_event_i,
	output wire       thermal_int_request_o,
	output wire       thermal_alarm_mode_select_o,
	input  wire       interrupt_input_global_enable_i,
	output wire       fourth_id_irq_o,
	output wire       fifth_id_irq_o,
	// Primary first interrupt status register contents
	input  wire [7:0] primary_status_i
);

	localparam [1:0] ST_IDLE  = 2'b01;
	localparam [1:0] ST_PULSE = 2'b10;
	localparam [23:0] PULSE_LAST =
		INTRUSION_PULSE_CYCLES[23:0] - 24'h000001;
	// Whole-byte reset value; bit 7 lives in the state machine
	localparam [7:0] INTR_RESET = `MA_INTRUSION_RESET;

	reg  [1:0]  state_r;
	reg  [1:0]  state_nxt;
	reg  [23:0] pulse_cnt_r;
	reg  [23:0] pulse_cnt_nxt;
	reg  [6:0]  intrusion_rsv_r;
	reg  [3:0]  fan_div_r;
	reg  [6:0]  fifth_rsv_r;
	reg  [7:0]  cfg2_r;
	reg  [7:0]  int_limit_r;
	reg  [7:0]  ext_limit_r;
	reg  [7:0]  rdata_nxt;
	wire [7:0]  fan_ratio;
	wire        restore;
	wire        wr_intr;
	wire        start_req;
	wire        pulse_done;
	wire        sel_cfg1;
	wire        sel_intr;
	wire        sel_div;
	wire        sel_fifth;
	wire        sel_cfg2;
	wire        sel_mirror;
	wire        sel_int_lim;
	wire        sel_ext_lim;
	wire        wr_div;
	wire        wr_fifth;
	wire        wr_cfg2;
	wire        wr_int_lim;
	wire        wr_ext_lim;
	wire        pulse_active;
	wire [7:0]  lock_keep;
	wire        id3_irq_armed;
	wire        id4_irq_armed;

	// Divider code to ratio; shared by both fans
	function [3:0] div_ratio;
		input [1:0] code;
		begin
			if (code == `MA_DIV_CODE_1)
				div_ratio = `MA_DIV_RATIO_1;
			else if (code == `MA_DIV_CODE_2)
				div_ratio = `MA_DIV_RATIO_2;
			else if (code == `MA_DIV_CODE_4)
				div_ratio = `MA_DIV_RATIO_4;
			else
				div_ratio = `MA_DIV_RATIO_8;
		end
	endfunction

	// True when an access targets the given offset
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	// Address decode, one select per register
	assign sel_cfg1    = hit(reg_addr_i, `MA_ADDR_FIRST_CONFIG);
	assign sel_intr    = hit(reg_addr_i, `MA_ADDR_INTRUSION_CLEAR);
	assign sel_div     = hit(reg_addr_i, `MA_ADDR_VID_FAN_DIV);
	assign sel_fifth   = hit(reg_addr_i, `MA_ADDR_FIFTH_VID);
	assign sel_cfg2    = hit(reg_addr_i, `MA_ADDR_SECOND_CONFIG);
	assign sel_mirror  = hit(reg_addr_i, `MA_ADDR_STATUS_MIRROR);
	assign sel_int_lim = hit(reg_addr_i, `MA_ADDR_INT_HIGH_LIMIT);
	assign sel_ext_lim = hit(reg_addr_i, `MA_ADDR_EXT_HIGH_LIMIT);

	// Config register 1 lives elsewhere; only its restore bit is watched
	assign restore = reg_wr_i & sel_cfg1 &
		reg_wdata_i[`MA_RESTORE_DEFAULTS_BIT];

	// Write enables
	assign wr_intr   = reg_wr_i & sel_intr;
	assign wr_div    = reg_wr_i & sel_div;
	assign wr_fifth  = reg_wr_i & sel_fifth;
	assign wr_cfg2   = reg_wr_i & sel_cfg2;
	assign start_req = wr_intr & reg_wdata_i[`MA_INTRUSION_REQ_BIT];

	// Limit writes are dropped while the matching lock is set
	assign wr_int_lim = reg_wr_i & sel_int_lim &
		~cfg2_r[`MA_CFG2_INT_LIMIT_LOCK];
	assign wr_ext_lim = reg_wr_i & sel_ext_lim &
		~cfg2_r[`MA_CFG2_EXT_LIMIT_LOCK];

	// Lock bits are sticky; a written zero cannot release them
	assign lock_keep = cfg2_r & ((8'h01 << `MA_CFG2_INT_LIMIT_LOCK) |
		(8'h01 << `MA_CFG2_EXT_LIMIT_LOCK));

	assign pulse_active = (state_r == ST_PULSE);

	// Count only while the wire is really low, so a slow pull-up or a
	// stuck line cannot shorten the pulse below its minimum
	assign pulse_done = pulse_active &
		(pulse_cnt_r == PULSE_LAST);

	always @* begin
		state_nxt = state_r;
		pulse_cnt_nxt = pulse_cnt_r;
		case (state_r)
			ST_IDLE: begin
				// Counter parked at zero between pulses
				pulse_cnt_nxt = 24'h000000;
				if (start_req) begin
					state_nxt = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (pulse_done) begin
					pulse_cnt_nxt = 24'h000000;
					// A fresh request in the final cycle wins
					if (!start_req) begin
						state_nxt = ST_IDLE;
					end
				end else if (!chassis_intrusion_pin_i) begin
					pulse_cnt_nxt = pulse_cnt_r + 24'h000001;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				pulse_cnt_nxt = 24'h000000;
			end
		endcase
		// Restore aborts a running pulse at once
		if (restore) begin
			state_nxt = ST_IDLE;
			pulse_cnt_nxt = 24'h000000;
		end
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_r <= ST_IDLE;
			pulse_cnt_r <= 24'h000000;
		end else begin
			state_r <= state_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
		end
	end

	// Open drain: drive low only; enable is active low
	assign chassis_intrusion_pin_o = 1'b0;
	assign chassis_intrusion_pin_oe_n_o = ~pulse_active;

	// Intrusion register reserved bits
	always @(posedge ref_clk_i) begin
		if (reset_i || restore) begin
			intrusion_rsv_r <= INTR_RESET[6:0];
		end else if (wr_intr) begin
			intrusion_rsv_r <= reg_wdata_i[6:0];
		end
	end

	// Fan divisor nibble
	always @(posedge ref_clk_i) begin
		if (reset_i || restore) begin
			fan_div_r <= `MA_FAN_DIV_RESET;
		end else if (wr_div) begin
			fan_div_r <= reg_wdata_i[7:4];
		end
	end

	// Fifth-ID reserved bits
	always @(posedge ref_clk_i) begin
		if (reset_i || restore) begin
			fifth_rsv_r <= `MA_FIFTH_VID_RSV_RESET;
		end else if (wr_fifth) begin
			fifth_rsv_r <= reg_wdata_i[7:1];
		end
	end

	// Second configuration; reserved bits 4 and 5 are never stored
	always @(posedge ref_clk_i) begin
		if (reset_i || restore) begin
			cfg2_r <= `MA_SECOND_CONFIG_RESET;
		end else if (wr_cfg2) begin
			cfg2_r <= (reg_wdata_i & `MA_CFG2_WRITABLE_MASK) |
				lock_keep;
		end
	end

	// Temperature high limits; not part of the restored set
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			int_limit_r <= `MA_HIGH_LIMIT_RESET;
		end else if (wr_int_lim) begin
			int_limit_r <= reg_wdata_i;
		end
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			ext_limit_r <= `MA_HIGH_LIMIT_RESET;
		end else if (wr_ext_lim) begin
			ext_limit_r <= reg_wdata_i;
		end
	end

	assign int_temp_high_limit_o = int_limit_r;
	assign ext_temp_high_limit_o = ext_limit_r;

	// Tachometer counts outside are prescaled by these ratios
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_fan
			assign fan_ratio[gi*4 +: 4] =
				div_ratio(fan_div_r[gi*2 +: 2]);
		end
	endgenerate

	assign first_fan_divider_o = fan_ratio[3:0];
	assign second_fan_divider_o = fan_ratio[7:4];

	// Mask only the interrupt path; alarm pin logic sees the raw event
	assign thermal_int_request_o = thermal_event_i &
		~cfg2_r[`MA_CFG2_THERMAL_ALARM_OUT_INT_MASK];
	assign thermal_alarm_mode_select_o =
		cfg2_r[`MA_CFG2_ALARM_MODE];
	// Each pin needs the global enable as well as its own select bit
	assign id3_irq_armed = interrupt_input_global_enable_i &
		cfg2_r[`MA_CFG2_ID3_IRQ_SEL];
	assign id4_irq_armed = interrupt_input_global_enable_i &
		cfg2_r[`MA_CFG2_ID4_IRQ_SEL];
	// The pins keep feeding the ID readback whatever their role
	assign fourth_id_irq_o = id3_irq_armed &
		voltage_id_low_nibble_i[3];
	assign fifth_id_irq_o = id4_irq_armed &
		fifth_voltage_id_input_i;

	// Read mux; foreign offsets such as the first configuration read zero
	always @* begin
		rdata_nxt = `MA_READ_UNMAPPED;
		if (sel_intr) begin
			rdata_nxt = {pulse_active, intrusion_rsv_r};
		end else if (sel_div) begin
			rdata_nxt = {fan_div_r, voltage_id_low_nibble_i};
		end else if (sel_fifth) begin
			rdata_nxt = {fifth_rsv_r, fifth_voltage_id_input_i};
		end else if (sel_cfg2) begin
			rdata_nxt = cfg2_r;
		end else if (sel_mirror) begin
			// No clear strobe is raised, so the primary flags survive
			rdata_nxt = primary_status_i;
		end else if (sel_int_lim) begin
			rdata_nxt = int_limit_r;
		end else if (sel_ext_lim) begin
			rdata_nxt = ext_limit_r;
		end
	end

	// Captured only on a read strobe, so the byte stands until the next read
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= `MA_READ_UNMAPPED;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
		end
	end

endmodule // monitor_aux_control_registers
`default_nettype wire

// *** testbench/monitor_aux_asserts.sv ***
// Purpose: Port checks for the auxiliary monitor register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Pulse length is counted in pin-low cycles only.
`timescale 1ns/1ps
`default_nettype none
module monitor_aux_asserts #(
	parameter integer INTRUSION_PULSE_CYCLES = 16
) (
	// Clock, reset and register port
	input wire logic       ref_clk_i,
	input wire logic       reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Pins and routing outputs
	input wire logic       chassis_intrusion_pin_i,
	input wire logic       chassis_intrusion_pin_oe_n_o,
	input wire logic [3:0] voltage_id_low_nibble_i,
	input wire logic       fifth_voltage_id_input_i,
	input wire logic [3:0] first_fan_divider_o,
	input wire logic [3:0] second_fan_divider_o,
	input wire logic       thermal_event_i,
	input wire logic       thermal_int_request_o,
	input wire logic       interrupt_input_global_enable_i,
	input wire logic       fourth_id_irq_o,
	input wire logic       fifth_id_irq_o,
	input wire logic [7:0] primary_status_i
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic [23:0] low_cnt_r;
	wire oe_n = chassis_intrusion_pin_oe_n_o;
	wire rd47 = reg_rd_i && reg_addr_i == 8'h47;
	always @(posedge ref_clk_i)
		if (reset_i || oe_n) low_cnt_r <= 24'h000000;
		else if (!chassis_intrusion_pin_i) low_cnt_r <= low_cnt_r + 24'h1;
	property p_start;
		reg_wr_i && reg_addr_i == 8'h46 && reg_wdata_i[7] |=> !oe_n;
	endproperty
	a_start: assert property (p_start) else $error("pulse not started");
	property p_len;
		$rose(oe_n) |-> low_cnt_r >= INTRUSION_PULSE_CYCLES;
	endproperty
	a_len: assert property (p_len) else $error("pulse too short");
	property p_end;
		$fell(oe_n) |-> ##[1:1000] oe_n;
	endproperty
	a_end: assert property (p_end) else $error("pulse never ends");
	property p_mirror;
		reg_rd_i && reg_addr_i == 8'h4C |=>
			reg_rdata_o == $past(primary_status_i);
	endproperty
	a_mirror: assert property (p_mirror) else $error("bad mirror");
	property p_vid;
		rd47 |=> reg_rdata_o[3:0] == $past(voltage_id_low_nibble_i);
	endproperty
	a_vid: assert property (p_vid) else $error("bad id nibble");
	property p_fifth_voltage_id_input;
		reg_rd_i && reg_addr_i == 8'h49 |=>
			reg_rdata_o[0] == $past(fifth_voltage_id_input_i);
	endproperty
	a_fifth_voltage_id_input: assert property (p_fifth_voltage_id_input) else $error("bad fifth id");
	property p_div;
		$onehot(first_fan_divider_o) && $onehot(second_fan_divider_o);
	endproperty
	a_div: assert property (p_div) else $error("bad divider");
	property p_mask;
		thermal_int_request_o |-> thermal_event_i;
	endproperty
	a_mask: assert property (p_mask) else $error("bad thermal int");
	property p_irq;
		(fourth_id_irq_o |-> interrupt_input_global_enable_i &&
			voltage_id_low_nibble_i[3]) and (fifth_id_irq_o |->
			interrupt_input_global_enable_i && fifth_voltage_id_input_i);
	endproperty
	a_irq: assert property (p_irq) else $error("bad id irq");
	c_pulse: cover property ($rose(oe_n));
	c_mirror: cover property (reg_rd_i && reg_addr_i == 8'h4C);
	c_irq: cover property (fourth_id_irq_o && fifth_id_irq_o);
endmodule // monitor_aux_asserts
`default_nettype wire

// *** testbench/host_model.sv ***
// Purpose: Serial-bus host side: register accesses and pin pull-up.
// Assumes: Read data settles one cycle after the read edge.
// Notes:   Released address and data show inverted values.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock and pin
	input  wire logic       ref_clk_i,
	input  wire logic       oe_n_i,
	output wire logic       pin_o,
	// Register port
	output logic      [7:0] addr_o = 8'h00,
	output logic      [7:0] wdata_o = 8'h00,
	output logic            wr_o = 1'b0,
	output logic            rd_o = 1'b0,
	input  wire logic [7:0] rdata_i
);
	// Pull-up: the line is low only while the bank pulls it
	assign pin_o = oe_n_i;
	task automatic acc(input logic [7:0] a, d, input logic w);
		@(posedge ref_clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= w;
		rd_o <= !w;
		@(posedge ref_clk_i);
		{wr_o, rd_o} <= 2'b00;
		addr_o <= ~a;
		wdata_o <= ~d;
		#1;
	endtask
endmodule // host_model
`default_nettype wire

// *** testbench/monitor_aux_control_registers_bench.sv ***
// Purpose: Self-checking bench of the auxiliary monitor register bank.
// Assumes: Shortened intrusion pulse of 16 counted cycles.
// Notes:   Checker attached by bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module monitor_aux_control_registers_bench;
	logic ref_clk_i = 1'b0, reset_i = 1'b1;
	logic [3:0] vid = 4'h9;
	logic fifth_voltage_id_input = 1'b1, thev = 1'b0, gen = 1'b0;
	logic [7:0] prim = 8'h00;
	wire [7:0] addr, wdata, rdata, lim_i, lim_e;
	wire wr, rd, pin, oe_n, thint, amode, irq3, irq4;
	wire [3:0] div1, div2;
	int bad_count = 0, n_compared = 0, n;
	always #5 ref_clk_i = ~ref_clk_i;
	host_model host_model_i (.ref_clk_i(ref_clk_i), .oe_n_i(oe_n),
		.pin_o(pin), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));
	monitor_aux_control_registers #(.INTRUSION_PULSE_CYCLES(16))
		monitor_aux_control_registers_i (.ref_clk_i(ref_clk_i),
		.reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.chassis_intrusion_pin_i(pin), .chassis_intrusion_pin_o(),
		.chassis_intrusion_pin_oe_n_o(oe_n),
		.voltage_id_low_nibble_i(vid), .fifth_voltage_id_input_i(fifth_voltage_id_input),
		.first_fan_divider_o(div1), .second_fan_divider_o(div2),
		.int_temp_high_limit_o(lim_i), .ext_temp_high_limit_o(lim_e),
		.thermal_event_i(thev), .thermal_int_request_o(thint),
		.thermal_alarm_mode_select_o(amode),
		.interrupt_input_global_enable_i(gen),
		.fourth_id_irq_o(irq3), .fifth_id_irq_o(irq4),
		.primary_status_i(prim));
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic w(input logic [7:0] a, d);
		host_model_i.acc(a, d, 1'b1);
	endtask
	task automatic rc(input logic [7:0] a, e);
		host_model_i.acc(a, 8'h00, 1'b0);
		chk($sformatf("reg %h", a), rdata, e);
	endtask
	task automatic t_div;
		for (int c = 0; c < 4; c++) begin
			@(posedge ref_clk_i) vid <= ~vid;
			w(8'h47, {c[1:0], c[1:0], 4'hF});
			chk("div1", div1, 8'h01 << c);
			chk("div2", div2, 8'h01 << c);
			rc(8'h47, {c[1:0], c[1:0], vid});
		end
		$display("test dividers done");
	endtask
	task automatic t_cfg;
		w(8'h4A, 8'hFF);
		rc(8'h4A, 8'hCF);
		chk("mode", amode, 8'h01);
		@(posedge ref_clk_i) {thev, gen, vid[3], fifth_voltage_id_input} <= 4'hF;
		@(posedge ref_clk_i) #1 chk("thermal_alarm_out", thint, 8'h00);
		chk("irq", {irq3, irq4}, 8'h03);
		@(posedge ref_clk_i) gen <= 1'b0;
		@(posedge ref_clk_i) #1 chk("irq", {irq3, irq4}, 8'h00);
		w(8'h4A, 8'h00);
		rc(8'h4A, 8'h06);
		chk("thermal_alarm_out", thint, 8'h01);
		chk("mode", amode, 8'h00);
		$display("test config done");
	endtask
	task automatic t_lock;
		w(8'h13, 8'hAA);
		w(8'h14, 8'h55);
		chk("limits", {lim_i[3:0], lim_e[3:0]}, 8'h00);
		w(8'h46, 8'h7F);
		rc(8'h46, 8'h7F);
		w(8'h49, 8'hFF);
		rc(8'h49, {7'h7F, fifth_voltage_id_input});
		w(8'h40, 8'h80);
		rc(8'h4A, 8'h00);
		rc(8'h46, 8'h00);
		rc(8'h49, {7'h40, fifth_voltage_id_input});
		rc(8'h47, {4'h5, vid});
		w(8'h13, 8'hAA);
		w(8'h14, 8'h55);
		chk("limits", {lim_i[3:0], lim_e[3:0]}, 8'hA5);
		$display("test lock done");
	endtask
	task automatic t_pulse;
		w(8'h46, 8'h80);
		chk("pin", pin, 8'h00);
		rc(8'h46, 8'h80);
		n = 0;
		while (oe_n !== 1'b1 && n < 100) begin
			@(posedge ref_clk_i) #1 n++;
		end
		chk("ended", n < 100, 8'h01);
		rc(8'h46, 8'h00);
		$display("test pulse done");
	endtask
	task automatic t_mirror;
		@(posedge ref_clk_i) prim <= 8'hA5;
		rc(8'h4C, 8'hA5);
		rc(8'h4C, 8'hA5);
		@(posedge ref_clk_i) prim <= 8'h5A;
		rc(8'h4C, 8'h5A);
		$display("test mirror done");
	endtask
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rc(8'h46, 8'h00);
		rc(8'h47, {4'h5, vid});
		rc(8'h49, {7'h40, fifth_voltage_id_input});
		rc(8'h4A, 8'h00);
		rc(8'h50, 8'h00);
		$display("test reset done");
		t_div();
		t_cfg();
		t_lock();
		t_pulse();
		t_mirror();
		give_verdict();
	end
	initial begin
		#100000;
		bad_count++;
		give_verdict();
	end
endmodule // monitor_aux_control_registers_bench
bind monitor_aux_control_registers monitor_aux_asserts #(
	.INTRUSION_PULSE_CYCLES(INTRUSION_PULSE_CYCLES)) monitor_aux_asserts_i (.*);
`default_nettype wire
